/* cacm_defines.svh */
// register addresses, field positions and reset values of the counter array channel block
`ifndef CACM_DEFINES_SVH
`define CACM_DEFINES_SVH
`define CACM_ADDR_PWMCFG 8'hd9
`define CACM_ADDR_CPM0 8'hda
`define CACM_ADDR_CNT_LO 8'hf9
`define CACM_ADDR_CNT_HI 8'hfa
`define CACM_ADDR_CAP_LO 8'hfb
`define CACM_ADDR_CAP_HI 8'hfc
`define CACM_ADDR_STATUS 8'hd8
`define CACM_BIT_WIDE 7
`define CACM_BIT_CMP 6
`define CACM_BIT_RISE 5
`define CACM_BIT_FALL 4
`define CACM_BIT_MATCH 3
`define CACM_BIT_TOG 2
`define CACM_BIT_PWM 1
`define CACM_BIT_IRQ 0
`define CACM_BIT_FLAG 0
`define CACM_BIT_RUN 6
`define CACM_CYCLE_LENGTH_FIELD_LSB 0
`define CACM_MODE_RESET 8'h00
`define CACM_BYTE_RESET 8'h00
`define CACM_CYCLE_LENGTH_FIELD_8 3'h0
`define CACM_CYCLE_LENGTH_FIELD_9 3'h1
`define CACM_CYCLE_LENGTH_FIELD_10 3'h2
`define CACM_CYCLE_LENGTH_FIELD_11 3'h3
`endif

/* cacm_pkg.sv */
// types shared by the counter array channel block
package cacm_pkg;
  typedef struct packed {
    logic wide;
    logic cmp;
    logic rise;
    logic fall;
    logic match;
    logic toggle_enable;
    logic pwm;
    logic irq;
  } cacm_mode_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cacm_sfr_s;
endpackage

/* cacm_edge.sv */
// two-flop pin synchroniser with registered rise and fall detection
module cacm_edge (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } cacm_edge_s;
  cacm_edge_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.rise = st_q.s2 & ~st_q.s3;
    st_d.fall = ~st_q.s2 & st_q.s3;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = st_q.rise;
  assign fall = st_q.fall;
endmodule // cacm_edge

/* cacm_channel.sv */
// counter array: 16-bit counter plus channel 0 capture, compare, toggle, pwm and frequency output
// What this block does
// - bit 7 picks 16-bit versus 8-11 bit pwm
// - bit 6 enables compare; cleared means none
// - bit 5 captures on rising pin edges
// - bit 4 captures falling edges; both gives either
// - bit 3 sets flag on counter match
// - bit 2 toggles pin on counter match
// - toggle plus pwm gives frequency output
// - bit 1 drives pwm waveform on pin
// - bit 0 gates flag onto interrupt request
// - counter low byte readable and writable
// - low byte read snapshots the high byte
// - cycle length field picks 8/9/10/11 bits
`include "cacm_defines.svh"
module cacm_channel
  import cacm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic count_tick,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic channel0_pin_in,
  output logic channel0_pin_out,
  output logic channel0_pin_oe,
  output logic irq_req
);
  typedef struct packed {
    cacm_mode_s mode;
    logic [15:0] count;
    logic [7:0] hi_snap;
    logic [15:0] capcmp;
    logic [10:0] reload;
    logic [2:0] cyc_len;
    logic reload_sel;
    logic flag;
    logic run;
    logic pin;
    logic [7:0] rdata;
  } cacm_state_s;

  cacm_state_s st_q, st_d;
  cacm_sfr_s bus;
  logic edge_rise, edge_fall;
  logic match_hit, capture_hit, cyc_wrap, pwm_mode, freq_mode;
  logic [15:0] cyc_mask;

  // counter bits that make up one pwm cycle for the selected length
  function automatic logic [15:0] len_mask(input logic [2:0] sel);
    unique case (sel)
      `CACM_CYCLE_LENGTH_FIELD_8: len_mask = 16'h00ff;
      `CACM_CYCLE_LENGTH_FIELD_9: len_mask = 16'h01ff;
      `CACM_CYCLE_LENGTH_FIELD_10: len_mask = 16'h03ff;
      `CACM_CYCLE_LENGTH_FIELD_11: len_mask = 16'h07ff;
      default: len_mask = 16'h00ff;
    endcase
  endfunction

  cacm_edge u_edge (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin(channel0_pin_in),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  assign bus = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};
  assign cyc_mask = len_mask(st_q.cyc_len);
  assign pwm_mode = st_q.mode.pwm & ~st_q.mode.toggle_enable;
  assign freq_mode = st_q.mode.pwm & st_q.mode.toggle_enable;
  // compare only acts while enabled and the counter is running
  assign match_hit = st_q.mode.cmp & st_q.run & count_tick &
    (st_q.count[7:0] == st_q.capcmp[7:0]) &
    (freq_mode | (st_q.count[15:8] == st_q.capcmp[15:8]));
  assign capture_hit = (st_q.mode.rise & edge_rise) | (st_q.mode.fall & edge_fall);
  assign cyc_wrap = ((st_q.count & cyc_mask) == cyc_mask) & st_q.run & count_tick;

  always_comb begin
    st_d = st_q;
    if (st_q.run && count_tick) begin
      st_d.count = st_q.count + 16'h0001;
    end
    if (bus.rd && bus.addr == `CACM_ADDR_CNT_LO) begin
      st_d.hi_snap = st_q.count[15:8];
    end
    // read data registered one cycle after the strobe
    st_d.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `CACM_ADDR_CPM0: st_d.rdata = st_q.mode;
        `CACM_ADDR_CNT_LO: st_d.rdata = st_q.count[7:0];
        `CACM_ADDR_CNT_HI: st_d.rdata = st_q.hi_snap;
        `CACM_ADDR_CAP_LO: st_d.rdata = st_q.reload_sel ? st_q.reload[7:0] : st_q.capcmp[7:0];
        `CACM_ADDR_CAP_HI: st_d.rdata = st_q.reload_sel ? {5'h00, st_q.reload[10:8]} : st_q.capcmp[15:8];
        `CACM_ADDR_PWMCFG: st_d.rdata = {st_q.reload_sel, 4'h0, st_q.cyc_len};
        `CACM_ADDR_STATUS: st_d.rdata = {1'b0, st_q.run, 5'h00, st_q.flag};
        default: st_d.rdata = 8'h00;
      endcase
    end
    // 8-11 bit pwm reloads its compare value, masked to the cycle length, at each cycle wrap
    if (cyc_wrap && pwm_mode && !st_q.mode.wide) begin
      st_d.capcmp = {5'h00, st_q.reload} & cyc_mask;
    end
    if (match_hit && st_q.mode.match) begin
      st_d.flag = 1'b1;
    end
    if (match_hit && st_q.mode.toggle_enable) begin
      st_d.pin = ~st_q.pin;
      if (freq_mode) begin
        st_d.capcmp[7:0] = 8'(st_q.capcmp[7:0] + st_q.capcmp[15:8]);
      end
    end
    if (pwm_mode) begin
      // pin low while counter below compare value, high from match to wrap
      if (st_q.mode.wide) begin
        st_d.pin = st_q.mode.cmp & (st_q.count >= st_q.capcmp);
      end else begin
        st_d.pin = st_q.mode.cmp & ((st_q.count & cyc_mask) >= (st_q.capcmp & cyc_mask));
      end
    end
    if (bus.wr) begin
      unique case (bus.addr)
        `CACM_ADDR_CPM0: st_d.mode = bus.wdata;
        `CACM_ADDR_CNT_LO: st_d.count[7:0] = bus.wdata;
        `CACM_ADDR_CNT_HI: st_d.count[15:8] = bus.wdata;
        `CACM_ADDR_CAP_LO: begin
          if (st_q.reload_sel) begin
            st_d.reload[7:0] = bus.wdata;
          end else begin
            st_d.capcmp[7:0] = bus.wdata;
          end
          st_d.mode.cmp = 1'b0;
        end
        `CACM_ADDR_CAP_HI: begin
          if (st_q.reload_sel) begin
            st_d.reload[10:8] = bus.wdata[2:0];
          end else begin
            st_d.capcmp[15:8] = bus.wdata;
          end
          st_d.mode.cmp = 1'b1;
        end
        `CACM_ADDR_PWMCFG: begin
          st_d.reload_sel = bus.wdata[7];
          st_d.cyc_len = bus.wdata[`CACM_CYCLE_LENGTH_FIELD_LSB +: 3];
        end
        `CACM_ADDR_STATUS: begin
          st_d.run = bus.wdata[`CACM_BIT_RUN];
          st_d.flag = bus.wdata[`CACM_BIT_FLAG];
        end
        default: st_d.mode = st_d.mode;
      endcase
    end
    // hardware events beat a software clear in the same cycle
    if (capture_hit) begin
      st_d.capcmp = st_q.count;
      st_d.flag = 1'b1;
    end
    if (match_hit && st_q.mode.match) begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata = st_q.rdata;
  assign channel0_pin_out = st_q.pin;
  assign channel0_pin_oe = st_q.mode.toggle_enable | st_q.mode.pwm;
  assign irq_req = st_q.mode.irq & st_q.flag;
endmodule // cacm_channel

/* cacm_pin_model.sv */
// outside circuit on the channel pin
module cacm_pin_model (
  input wire logic clock,
  input wire logic lvl,
  input wire logic oe,
  input wire logic drv,
  output logic pin
);
  // the pad reads back our own drive while the channel enables it
  always_ff @(posedge clock) pin <= oe ? drv : lvl;
endmodule // cacm_pin_model

/* cacm_channel_props.sv */
// port checks of the channel block
module cacm_channel_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic count_tick,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic channel0_pin_in,
  input wire logic channel0_pin_out,
  input wire logic channel0_pin_oe,
  input wire logic irq_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00) else $error("unmapped");
  a_mode_readback: assert property (sfr_wr && sfr_addr == 8'hda ##1 sfr_rd && sfr_addr == 8'hda
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("mode readback");
  a_count_low_rw: assert property (sfr_wr && sfr_addr == 8'hf9 && !count_tick ##1 sfr_rd && sfr_addr == 8'hf9
    && !count_tick |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("count low");
  a_irq_masked: assert property (sfr_wr && sfr_addr == 8'hda && !sfr_wdata[0] |=> ##1 !irq_req) else $error("irq");
  a_oe_off: assert property (sfr_wr && sfr_addr == 8'hda && sfr_wdata[2:1] == 2'h0 |=> ##1 !channel0_pin_oe)
    else $error("oe");
  a_irq_flag: assert property (sfr_rd && sfr_addr == 8'hd8 && irq_req |=> sfr_rdata[0]) else $error("flag");
  a_reset_quiet: assert property (disable iff (1'h0) $fell(sys_rst) |-> !irq_req && !channel0_pin_oe
    && sfr_rdata == 8'h00) else $error("reset");
endmodule // cacm_channel_props
bind cacm_channel cacm_channel_props cacm_channel_props_i (.clock, .sys_rst, .count_tick, .sfr_wr, .sfr_rd,
  .sfr_addr, .sfr_wdata, .sfr_rdata, .channel0_pin_in, .channel0_pin_out, .channel0_pin_oe, .irq_req);

/* cacm_channel_tb.sv */
// testbench of the channel block
module cacm_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", n, e, v); end end
  logic clock = '0, sys_rst = 1'h1, count_tick = '0, sfr_wr = '0, sfr_rd = '0, lvl = '0;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, rd_q;
  logic pin_in, pin_out, pin_oe, irq_req;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  cacm_channel cacm_channel_i (.clock, .sys_rst, .count_tick, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .channel0_pin_in(pin_in), .channel0_pin_out(pin_out), .channel0_pin_oe(pin_oe), .irq_req);
  cacm_pin_model cacm_pin_model_i (.clock, .lvl, .oe(pin_oe), .drv(pin_out), .pin(pin_in));
  // strobes stay up at return so that accesses can run back to back
  task automatic acc(input logic w, input logic [7:0] a, d);
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clock);
    rd_q = sfr_rdata;
  endtask
  task automatic idle(int n);
    sfr_wr = '0;
    sfr_rd = '0;
    repeat (n) @(negedge clock);
  endtask
  task automatic tick;
    count_tick = 1'h1;
    @(negedge clock);
    count_tick = '0;
    repeat (3) @(negedge clock);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_regs;
    acc(0, 8'hda, 0); `CHK("mode", 8'h00, rd_q)
    acc(1, 8'hf9, 8'ha5);
    acc(0, 8'hf9, 0); `CHK("count lo", 8'ha5, rd_q)
    acc(1, 8'hda, 8'h81);
    acc(0, 8'hda, 0); `CHK("mode rw", 8'h81, rd_q)
    acc(1, 8'hf9, 8'hff);
    acc(1, 8'hd8, 8'h40);
    idle(1);
    tick;
    acc(0, 8'hfa, 0); `CHK("old snap", 8'h00, rd_q)
    acc(0, 8'hf9, 0); `CHK("carry lo", 8'h00, rd_q)
    acc(0, 8'hfa, 0); `CHK("new snap", 8'h01, rd_q)
    $display("regs done");
  endtask
  task automatic t_capture;
    acc(1, 8'hda, 8'h21);
    idle(1);
    lvl = 1'h1;
    idle(8);
    `CHK("irq", 1'h1, irq_req)
    acc(0, 8'hfc, 0); `CHK("capture hi", 8'h01, rd_q)
    acc(1, 8'hd8, 8'h40);
    acc(1, 8'hda, 8'h10);
    idle(1);
    lvl = '0;
    idle(8);
    acc(0, 8'hd8, 0); `CHK("fall flag", 8'h41, rd_q)
    `CHK("irq masked", 1'h0, irq_req)
    $display("capture done");
  endtask
  task automatic t_compare;
    acc(1, 8'hfb, 8'h01);
    acc(1, 8'hfc, 8'h01);
    acc(1, 8'hd8, 8'h40);
    acc(1, 8'hda, 8'h4c);
    idle(2);
    `CHK("oe", 1'h1, pin_oe)
    // counter stands one below the compare value, so the second tick matches
    tick;
    tick;
    `CHK("toggled", 1'h1, pin_out)
    acc(0, 8'hd8, 0); `CHK("match flag", 8'h41, rd_q)
    acc(1, 8'hda, 8'h42);
    idle(3);
    `CHK("pwm high", 1'h1, pin_out)
    acc(1, 8'hfb, 8'h02);
    idle(3);
    `CHK("pwm off", 1'h0, pin_out)
    $display("compare done");
  endtask
  // counter is 16'h0102 here; compare becomes 16'h0202 so the widths disagree
  task automatic t_pwm;
    acc(1, 8'hfc, 8'h02);
    acc(1, 8'hda, 8'hc2);
    idle(3);
    `CHK("wide pwm low", 1'h0, pin_out)
    acc(1, 8'hda, 8'h42);
    idle(3);
    `CHK("byte pwm high", 1'h1, pin_out)
    acc(1, 8'hd9, 8'h02);
    idle(3);
    `CHK("10 bit pwm low", 1'h0, pin_out)
    acc(1, 8'hda, 8'h46);
    acc(1, 8'hd9, 8'h00);
    idle(1);
    tick;
    `CHK("freq toggle", 1'h1, pin_out)
    acc(0, 8'hfb, 8'h00); `CHK("freq step", 8'h04, rd_q)
    $display("pwm done");
  endtask
  initial forever #2.5 clock = !clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc > 2000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(negedge clock);
    sys_rst = '0;
    t_regs;
    t_capture;
    t_compare;
    t_pwm;
    stop_test;
  end
endmodule // cacm_channel_tb
